// [rtl/abs_map.svh]
`ifndef ABS_MAP_SVH
`define ABS_MAP_SVH
// ****************************************************************
// register map
// ****************************************************************
`define ABS_REG_CTRL   12'h000
`define ABS_REG_STAT   12'h004
`define ABS_CTRL_PWR   0
`define ABS_CTRL_VREF  1
`define ABS_CTRL_CH_LO 4
`define ABS_CTRL_START 8
`define ABS_STAT_BUSY  16
`define ABS_STAT_DONE  17
`define ABS_STAT_SCAN  18
// ****************************************************************
// conversion timing and chain layout
// ****************************************************************
`define ABS_SAMPLE_CYC 4'h8
`define ABS_EVAL_CYC   4'h3
`define ABS_DAC_MID    10'h200
`define ABS_DAC_ONE    10'h001
`define ABS_MSB        4'h9
`define ABS_CH_ONE     8'h01
`define ABS_CHAIN_W    36
// idle values: hold 1, dac 0x200, extch 1, mux bit 0, passgate 1, precharge 1
`define ABS_IDLE_CTRL {1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 10'h200, 1'h1, 1'h0, \
                       1'h1, 1'h0, 8'h01, 3'h0, 1'h1, 1'h1, 1'h0, 1'h0}
`endif

// [rtl/abs_pkg.sv]
`default_nettype none
`include "abs_map.svh"
package abs_pkg;
  typedef struct packed {
    logic       aclk;
    logic       acten;
    logic       switchcap_test_en;
    logic       adcbgen;
    logic       converter_power_on;
    logic       amp_power_on;
    logic [9:0] dac;
    logic       extch;
    logic       gnden;
    logic       hold;
    logic       bandgap_dac_ref_en;
    logic [7:0] pos_input_select;
    logic [2:0] neg_input_select;
    logic       amp_passgate_en;
    logic       cmp_latch_precharge_n;
    logic       settle_assist;
    logic       supply_ref_select;
  } abs_ctrl_s;

  typedef enum logic [2:0] {ABS_IDLE, ABS_SAMPLE, ABS_CMP_LATCH_PRECHARGE_N, ABS_EVAL, ABS_DONE} abs_sar_e;

  typedef struct packed {
    logic                    cmp_s1;
    logic                    cmp_s2;
    logic [`ABS_CHAIN_W-1:0] shift;
    abs_ctrl_s               upd;
    logic                    upd_tgl;
    logic                    scan_out;
  } abs_tck_s;

  typedef struct packed {
    logic        ext_s1;
    logic        ext_s2;
    logic        tg_s1;
    logic        tg_s2;
    logic        tg_s3;
    logic        cp_s1;
    logic        cp_s2;
    abs_ctrl_s   scan_word;
    abs_sar_e    sar;
    logic [3:0]  cnt;
    logic [3:0]  bitidx;
    logic [9:0]  result;
    logic        done;
    logic        power;
    logic        vref;
    logic [2:0]  chan;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    abs_ctrl_s   out;
  } abs_pclk_s;
endpackage
`default_nettype wire

// [rtl/abs_adc_scan.sv]
// Functional notes
// - hold low tracks the selected input, hold high freezes the sample
// - three-bit negative input select besides eight positive mux bits
// - comparator latch precharge is active low, high lets it evaluate
// - switch-cap test enable routes amplifier output to channel 4 pin
// - supply picks converter reference; separate bit picks band-gap for DAC
// - pass-gate of the amplifier enabled while its control is 1
// - normal conversion is successive approximation; scan check needs none
// - DAC value from ten control bits, bit 9 most significant
// - converter and amplifier each have their own power-on control
`default_nettype none
`include "abs_map.svh"
module abs_adc_scan (
  // apb clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // scan chain, test clock domain
  input  wire logic              tck,
  input  wire logic              test_reset_n,
  input  wire logic              scan_in,
  input  wire logic              scan_capture,
  input  wire logic              scan_shift,
  input  wire logic              scan_update,
  input  wire logic              scan_extest,
  output logic                   scan_out,
  // converter analog side
  input  wire logic              comp_in,
  output abs_pkg::abs_ctrl_s     adc_ctrl
);
  // ****************************************************************
  // test clock domain: chain and update cells
  // ****************************************************************
  abs_pkg::abs_tck_s t_cur, t_nxt;

  always_comb begin
    t_nxt = t_cur;
    t_nxt.cmp_s1 = comp_in;
    t_nxt.cmp_s2 = t_cur.cmp_s1;
    if (scan_capture) begin
      t_nxt.shift = {t_cur.upd, t_cur.cmp_s2};
    end else if (scan_shift) begin
      t_nxt.shift = {scan_in, t_cur.shift[`ABS_CHAIN_W-1:1]};
    end
    if (scan_update) begin
      t_nxt.upd     = abs_pkg::abs_ctrl_s'(t_cur.shift[`ABS_CHAIN_W-1:1]);
      t_nxt.upd_tgl = ~t_cur.upd_tgl;
    end
    t_nxt.scan_out = t_nxt.shift[0];
  end

  always_ff @(posedge tck or negedge test_reset_n) begin
    if (!test_reset_n) begin
      t_cur.cmp_s1   <= 1'h0;
      t_cur.cmp_s2   <= 1'h0;
      t_cur.shift    <= '0;
      t_cur.upd      <= `ABS_IDLE_CTRL;
      t_cur.upd_tgl  <= 1'h0;
      t_cur.scan_out <= 1'h0;
    end else begin
      t_cur <= t_nxt;
    end
  end

  assign scan_out = t_cur.scan_out;

  // ****************************************************************
  // apb domain: crossing, conversion engine, registers
  // ****************************************************************
  abs_pkg::abs_pclk_s c, n;
  abs_pkg::abs_ctrl_s norm;
  logic               setup;
  logic               wr;
  logic               busy;
  logic [9:0]         trial;
  logic [31:0]        rd;
  logic               mapped;

  always_comb begin
    n      = c;
    setup  = psel && !penable;
    wr     = psel && penable && c.pready && pwrite;
    busy   = (c.sar != abs_pkg::ABS_IDLE);
    trial  = c.result | (`ABS_DAC_ONE << c.bitidx);
    mapped = (paddr == `ABS_REG_CTRL) || (paddr == `ABS_REG_STAT);
    rd     = 32'h0;
    // level and toggle crossings from the test clock, and the comparator input synchroniser
    n.ext_s1 = scan_extest;
    n.ext_s2 = c.ext_s1;
    n.tg_s1  = t_cur.upd_tgl;
    n.tg_s2  = c.tg_s1;
    n.tg_s3  = c.tg_s2;
    n.cp_s1  = comp_in;
    n.cp_s2  = c.cp_s1;
    // word is stable for many cycles after its toggle, so sampling it here is safe
    if (c.tg_s3 != c.tg_s2) begin
      n.scan_word = t_cur.upd;
    end
    // register writes
    if (wr && paddr == `ABS_REG_CTRL) begin
      n.power = pwdata[`ABS_CTRL_PWR];
      n.vref  = pwdata[`ABS_CTRL_VREF];
      n.chan  = pwdata[`ABS_CTRL_CH_LO +: 3];
    end
    if (wr && paddr == `ABS_REG_STAT && pwdata[`ABS_STAT_DONE]) begin
      n.done = 1'h0;
    end
    unique case (c.sar)
      abs_pkg::ABS_IDLE: begin
        if (wr && paddr == `ABS_REG_CTRL && pwdata[`ABS_CTRL_START] && !c.ext_s2) begin
          n.sar    = abs_pkg::ABS_SAMPLE;
          n.cnt    = `ABS_SAMPLE_CYC;
          n.result = 10'h000;
          n.bitidx = `ABS_MSB;
        end
      end
      abs_pkg::ABS_SAMPLE: begin
        n.cnt = c.cnt - 4'h1;
        if (c.cnt == 4'h0) begin
          n.sar = abs_pkg::ABS_CMP_LATCH_PRECHARGE_N;
        end
      end
      abs_pkg::ABS_CMP_LATCH_PRECHARGE_N: begin
        n.sar = abs_pkg::ABS_EVAL;
        n.cnt = `ABS_EVAL_CYC;
      end
      abs_pkg::ABS_EVAL: begin
        n.cnt = c.cnt - 4'h1;
        if (c.cnt == 4'h0) begin
          // comparator high means dac above input, so drop the bit
          if (!c.cp_s2) begin
            n.result = trial;
          end
          if (c.bitidx == 4'h0) begin
            n.sar = abs_pkg::ABS_DONE;
          end else begin
            n.bitidx = c.bitidx - 4'h1;
            n.sar    = abs_pkg::ABS_CMP_LATCH_PRECHARGE_N;
          end
        end
      end
      abs_pkg::ABS_DONE: begin
        // set wins over a clear in the same cycle
        n.done = 1'h1;
        n.sar  = abs_pkg::ABS_IDLE;
      end
      // unused codes fall back to idle
      default: begin
        n.sar = abs_pkg::ABS_IDLE;
      end
    endcase
    // normal-mode analog controls
    norm                    = `ABS_IDLE_CTRL;
    norm.converter_power_on = c.power;
    norm.supply_ref_select  = c.vref;
    norm.pos_input_select   = `ABS_CH_ONE << c.chan;
    norm.hold               = (c.sar != abs_pkg::ABS_SAMPLE);
    norm.dac                = `ABS_DAC_MID;
    if (c.sar == abs_pkg::ABS_CMP_LATCH_PRECHARGE_N || c.sar == abs_pkg::ABS_EVAL) begin
      norm.dac = trial;
    end
    norm.cmp_latch_precharge_n = (c.sar != abs_pkg::ABS_CMP_LATCH_PRECHARGE_N);
    // scan values drive the converter while scan is selected
    n.out = c.ext_s2 ? c.scan_word : norm;
    // apb answer one cycle after setup
    rd[`ABS_CTRL_PWR]        = (paddr == `ABS_REG_CTRL) && c.power;
    rd[`ABS_CTRL_VREF]       = (paddr == `ABS_REG_CTRL) && c.vref;
    if (paddr == `ABS_REG_CTRL) begin
      rd[`ABS_CTRL_CH_LO +: 3] = c.chan;
    end else begin
      rd[9:0]            = c.result;
      rd[`ABS_STAT_BUSY] = busy;
      rd[`ABS_STAT_DONE] = c.done;
      rd[`ABS_STAT_SCAN] = c.ext_s2;
    end
    n.pready  = setup;
    n.pslverr = setup && !mapped;
    n.prdata  = (setup && mapped && !pwrite) ? rd : 32'h0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c           <= '0;
      c.scan_word <= `ABS_IDLE_CTRL;
      c.out       <= `ABS_IDLE_CTRL;
      c.sar       <= abs_pkg::ABS_IDLE;
    end else begin
      c <= n;
    end
  end

  assign pready   = c.pready;
  assign prdata   = c.prdata;
  assign pslverr  = c.pslverr;
  assign adc_ctrl = c.out;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_hold_sample;
    @(posedge pclk) disable iff (!presetn)
      (c.sar == abs_pkg::ABS_SAMPLE && !c.ext_s2) |=> !adc_ctrl.hold && adc_ctrl.dac == `ABS_DAC_MID;
  endproperty
  a_hold_sample: assert property (p_hold_sample) else $error("hold not low while sampling");

  property p_cmp_latch_precharge_n;
    @(posedge pclk) disable iff (!presetn)
      (c.sar == abs_pkg::ABS_CMP_LATCH_PRECHARGE_N && !c.ext_s2 && !n.ext_s2)
        |=> !adc_ctrl.cmp_latch_precharge_n ##1 adc_ctrl.cmp_latch_precharge_n;
  endproperty
  a_cmp_latch_precharge_n: assert property (p_cmp_latch_precharge_n) else $error("precharge pulse wrong");

  property p_scan_out;
    @(posedge pclk) disable iff (!presetn)
      c.ext_s2 |=> adc_ctrl == $past(c.scan_word);
  endproperty
  a_scan_out: assert property (p_scan_out) else $error("scan word not applied");

  property p_scan_pwr;
    @(posedge pclk) disable iff (!presetn)
      c.ext_s2 |=> adc_ctrl.amp_power_on == $past(c.scan_word.amp_power_on)
                && adc_ctrl.supply_ref_select == $past(c.scan_word.supply_ref_select);
  endproperty
  a_scan_pwr: assert property (p_scan_pwr) else $error("power or reference lost");

  property p_update;
    @(posedge tck) disable iff (!test_reset_n)
      scan_update |=> t_cur.upd == abs_pkg::abs_ctrl_s'($past(t_cur.shift[`ABS_CHAIN_W-1:1]));
  endproperty
  a_update: assert property (p_update) else $error("update cell wrong");

  property p_upd_hold;
    @(posedge tck) disable iff (!test_reset_n)
      !scan_update |=> $stable(t_cur.upd) && $stable(t_cur.upd_tgl);
  endproperty
  a_upd_hold: assert property (p_upd_hold) else $error("update cell moved");

  property p_capture;
    @(posedge tck) disable iff (!test_reset_n)
      scan_capture |=> t_cur.shift[0] == $past(t_cur.cmp_s2) && scan_out == $past(t_cur.cmp_s2);
  endproperty
  a_capture: assert property (p_capture) else $error("comparator not captured");

  property p_first_trial;
    @(posedge pclk) disable iff (!presetn)
      (c.sar == abs_pkg::ABS_CMP_LATCH_PRECHARGE_N && c.bitidx == `ABS_MSB && !c.ext_s2)
        |=> adc_ctrl.dac == `ABS_DAC_MID;
  endproperty
  a_first_trial: assert property (p_first_trial) else $error("first trial not msb");

  property p_done;
    @(posedge pclk) disable iff (!presetn)
      (c.sar == abs_pkg::ABS_EVAL && c.cnt == 4'h0 && c.bitidx == 4'h0) |=> ##1 c.done;
  endproperty
  a_done: assert property (p_done) else $error("done not set");

  property p_apb;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready ##1 !pready;
  endproperty
  a_apb: assert property (p_apb) else $error("apb answer timing");

  property p_scan_word;
    @(posedge pclk) disable iff (!presetn)
      (c.tg_s3 != c.tg_s2) |=> c.scan_word == $past(t_cur.upd);
  endproperty
  a_scan_word: assert property (p_scan_word) else $error("scan word not taken");

  property p_onehot_mux;
    @(posedge pclk) disable iff (!presetn)
      !c.ext_s2 |=> $onehot(adc_ctrl.pos_input_select);
  endproperty
  a_onehot_mux: assert property (p_onehot_mux) else $error("positive mux not one-hot");

  c_conv: cover property (@(posedge pclk) disable iff (!presetn) c.sar == abs_pkg::ABS_DONE);
  c_upd:  cover property (@(posedge tck) disable iff (!test_reset_n) scan_update);
  c_cap:  cover property (@(posedge tck) disable iff (!test_reset_n) scan_capture && t_cur.cmp_s2);
  c_ext:  cover property (@(posedge pclk) disable iff (!presetn) $rose(c.ext_s2));
endmodule
`default_nettype wire

// [tb/abs_tester.sv]
`default_nettype none
module abs_tester (
  // scan strobes toward the chain
  output logic      tck,
  output logic      test_reset_n,
  output logic      scan_in,
  output logic      scan_capture,
  output logic      scan_shift,
  output logic      scan_update,
  // serial data back
  input  wire logic scan_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // test clock and frame sequencer
  // ****************************************************************
  logic run = 1'b0;

  initial begin
    {scan_in, scan_capture, scan_shift, scan_update} = 4'h0;
    // a clean falling edge, so the async reset is seen without tck
    test_reset_n = 1'b1;
    #1 test_reset_n = 1'b0;
    #99 test_reset_n = 1'b1;
  end

  // clock stands still between frames, phase unrelated to pclk
  initial begin
    tck = 1'b0;
    #7;
    forever begin
      #15;
      if (run || tck) tck = ~tck;
    end
  end

  // lead-in edges let the comparator synchroniser settle before capture
  task automatic frame(input logic [34:0] w, output logic [35:0] got);
    run = 1'b1;
    repeat (4) @(posedge tck);
    scan_capture <= 1'b1;
    @(posedge tck);
    scan_capture <= 1'b0;
    scan_shift   <= 1'b1;
    scan_in      <= 1'b0;
    @(negedge tck) got[0] = scan_out;
    for (int i = 1; i < 36; i++) begin
      @(posedge tck) scan_in <= w[i-1];
      @(negedge tck) got[i] = scan_out;
    end
    @(posedge tck);
    scan_shift  <= 1'b0;
    scan_update <= 1'b1;
    @(posedge tck);
    scan_update <= 1'b0;
    scan_in     <= ~scan_in;
    run = 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb/test_abs_adc_scan.sv]
`default_nettype none
`include "abs_map.svh"
module test_abs_adc_scan;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // stimulus, analog stand-in and instances
  // ****************************************************************
  localparam logic [9:0] VIN = 10'h131;
  // hold and precharge per window step, step 0 in bit 0
  localparam logic [10:0] HOLD_PAT  = 11'h7BD;
  localparam logic [10:0] CMP_LATCH_PRECHARGE_N_PAT = 11'h5EF;
  logic               pclk    = 1'b0;
  logic               presetn = 1'b0;
  logic               psel    = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite  = 1'b0;
  logic [11:0]        paddr   = 12'h000;
  logic [31:0]        pwdata  = 32'h0;
  logic               scan_extest = 1'b0;
  logic               comp_in = 1'b0;
  logic               pready, pslverr, er;
  logic               tck, test_reset_n, scan_in, scan_capture, scan_shift;
  logic               scan_update, scan_out;
  logic [31:0]        prdata, rd;
  logic [35:0]        got;
  abs_pkg::abs_ctrl_s adc_ctrl, w, prev;
  int                 n_fail = 0;
  int                 cmp_count = 0;
  int                 k;

  initial forever #12.5 pclk = ~pclk;
  // comparator: high while the dac sits above the input
  always @(posedge pclk) comp_in <= (adc_ctrl.dac > VIN);

  abs_adc_scan uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .tck(tck), .test_reset_n(test_reset_n), .scan_in(scan_in),
    .scan_capture(scan_capture), .scan_shift(scan_shift), .scan_update(scan_update),
    .scan_extest(scan_extest), .scan_out(scan_out), .comp_in(comp_in), .adc_ctrl(adc_ctrl));

  abs_tester tst (.tck(tck), .test_reset_n(test_reset_n), .scan_in(scan_in),
    .scan_capture(scan_capture), .scan_shift(scan_shift), .scan_update(scan_update),
    .scan_out(scan_out));

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk35(input abs_pkg::abs_ctrl_s g, input abs_pkg::abs_ctrl_s e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // bounded wait for the access edge; read data taken at that edge only
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk35(adc_ctrl, `ABS_IDLE_CTRL);
    apb(1'b0, 12'h008, 32'h0);
    chk32({er, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, `ABS_REG_CTRL, 32'h0000_0033);
    repeat (3) @(posedge pclk);
    chk32({30'h0, adc_ctrl.supply_ref_select, adc_ctrl.converter_power_on}, 32'h3);
    chk32({24'h0, adc_ctrl.pos_input_select}, 32'h0000_0008);
    apb(1'b0, `ABS_REG_CTRL, 32'h0);
    chk32(rd, 32'h0000_0033);
    apb(1'b1, `ABS_REG_CTRL, 32'h0000_0133);
    repeat (3) @(posedge pclk);
    chk32({21'h0, adc_ctrl.hold, adc_ctrl.dac}, {21'h0, 1'b0, `ABS_DAC_MID});
    k = 0;
    rd = 32'h0;
    while (rd[`ABS_STAT_DONE] !== 1'b1 && k < 100) begin
      apb(1'b0, `ABS_REG_STAT, 32'h0);
      k++;
    end
    chk32(rd & 32'h0007_03FF, {13'h0, 3'h2, 6'h0, VIN});
    if (k == 100) begin
      n_fail++;
      print_verdict();
    end
    scan_extest <= 1'b1;
    prev = `ABS_IDLE_CTRL;
    w = {6'h0A, 10'h2A5, 4'hB, 8'h20, 3'h5, 4'h9};
    tst.frame(w, got);
    chk35(got[35:1], prev);
    repeat (10) @(posedge pclk);
    chk35(adc_ctrl, w);
    // start refused in scan mode, done cleared, scan flag seen
    apb(1'b1, `ABS_REG_CTRL, 32'h0000_0133);
    apb(1'b1, `ABS_REG_STAT, 32'h0002_0000);
    apb(1'b0, `ABS_REG_STAT, 32'h0);
    chk32(rd & 32'h0007_0000, 32'h0004_0000);
    chk35(adc_ctrl, w);
    prev = w;
    // amplifier stays off: aclk and settle assist low
    for (int i = 0; i < 11; i++) begin
      w.dac = (i == 3 || i == 4) ? 10'h123 : (i == 8 || i == 9) ? 10'h143 : `ABS_DAC_MID;
      w = {6'h02, w.dac, 2'h2, HOLD_PAT[i], 1'b0, 8'h08, 3'h0, 1'b1, CMP_LATCH_PRECHARGE_N_PAT[i], 2'h0};
      tst.frame(w, got);
      chk35(got[35:1], prev);
      if (i == 5 || i == 10) chk32({31'h0, got[0]}, {31'h0, i == 10});
      repeat (10) @(posedge pclk);
      chk35(adc_ctrl, w);
      prev = w;
    end
    print_verdict();
  end

  initial begin
    #400000;
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire
